// *** core/hmcpd_consts.svh ***
// Constants for the hardware mode strap pin decoder: offsets, fields, resets, timing
`ifndef HMCPD_CONSTS_SVH
`define HMCPD_CONSTS_SVH

// ****************************************
// Register byte offsets on the APB side
// ****************************************
`define HMCPD_OFS_SW_CFG 8'h00
`define HMCPD_OFS_STATUS 8'h04
`define HMCPD_OFS_VIOL 8'h08

// ****************************************
// Software configuration register fields
// ****************************************
`define HMCPD_CFG_TXSEQ_LSB 0
`define HMCPD_CFG_JIT_LSB 2
`define HMCPD_CFG_EQ_BIT 4
`define HMCPD_CFG_SLEEP_BIT 5
`define HMCPD_CFG_E1_BIT 6
`define HMCPD_CFG_WMASK 8'h7f
`define HMCPD_CFG_RESET 8'h00

// ****************************************
// Violation register fields (write one to clear)
// ****************************************
`define HMCPD_VIOL_JIT_BIT 0
`define HMCPD_VIOL_AD_BIT 1

// ****************************************
// Decoded values
// ****************************************
`define HMCPD_FIFO_BROAD 8'h40
`define HMCPD_FIFO_NARROW 8'h80
`define HMCPD_EQ_SHORT_DB 6'h0a
`define HMCPD_EQ_LONG_T1_DB 6'h24
`define HMCPD_EQ_LONG_E1_DB 6'h2b

// ****************************************
// Timing at the 40 MHz system clock
// ****************************************
`define HMCPD_CLK_PERIOD_NS 25
`define HMCPD_RST_MIN_NS 100
`define HMCPD_RST_MIN_CYC ((`HMCPD_RST_MIN_NS + `HMCPD_CLK_PERIOD_NS - 1) / `HMCPD_CLK_PERIOD_NS)

`endif

// *** core/hmcpd_pkg.sv ***
// Types shared by the hardware mode strap pin decoder
package hmcpd_pkg;

   // Control interface mode read from the two mode pins
   typedef enum logic [1:0]
   {
      HMCPD_MODE_HW = 2'h0,
      HMCPD_MODE_SERIAL = 2'h1,
      HMCPD_MODE_PAR_A = 2'h2,
      HMCPD_MODE_PAR_B = 2'h3
   } hmcpd_ctrl_mode_t;

   // APB slave answer sequencer, one-hot
   typedef enum logic [1:0]
   {
      HMCPD_APB_IDLE = 2'b01,
      HMCPD_APB_DONE = 2'b10
   } hmcpd_apb_state_t;

endpackage

// *** core/hmcpd_sync.sv ***
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps

module hmcpd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i, // System clock
   input wire logic rst_n_i, // Synchronised reset, active low
   input wire logic [WIDTH-1:0] async_i, // Levels from pins
   output logic [WIDTH-1:0] sync_o // Levels on the clock
);

   logic [WIDTH-1:0] meta_q;

   // One pair of flops for each bit; the first flop feeds only the second
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++)
      begin : g_bit
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               meta_q[gi] <= 1'b0;
               sync_o[gi] <= 1'b0;
            end
            else
            begin
               meta_q[gi] <= async_i[gi];
               sync_o[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

endmodule

// *** core/hmcpd_top.sv ***
// Hardware control mode strap decoder with APB configuration and status
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "hmcpd_consts.svh"

// Summary of operation
// R1: Pattern select: normal, ones, PRBS, power down
// R2: Attenuator 00 off; 01 receive, broad, 64
// R3: Attenuator 10 receive, 11 transmit; narrow, 128
// R4: Attenuator pins used only in hardware mode
// R5: Sleep pin high powers receiver down
// R6: Gain pin: 10 dB or 36/43 dB
// R7: Reset low over 100 ns resets
// R8: Master clock runs throughout reset
// R9: Float pin high tristates line driver
// R10: Float pin affects only the driver
// R11: Multiplexed modes share AD; serial ties low
// R12: Hardware mode only when mode pins 00
// R13: Synchronise straps; ignore in software modes (the float pin still acts in every mode)
module hmcpd_top
   import hmcpd_pkg::*;
(
   input wire logic sys_clk_i, // 40 MHz master clock
   input wire logic rst_n_i, // Chip reset, active low
   // APB slave
   input wire logic psel_i, // Slave select
   input wire logic penable_i, // Access phase
   input wire logic pwrite_i, // Write when high
   input wire logic [7:0] paddr_i, // Byte address
   input wire logic [31:0] pwdata_i, // Write data
   input wire logic [3:0] pstrb_i, // Write byte lanes
   output logic [31:0] prdata_o, // Read data
   output logic pready_o, // Transfer done
   output logic pslverr_o, // Unmapped address
   // Strap pins
   input wire logic [1:0] ctrl_mode_sel_i, // Control mode pins
   input wire logic [1:0] tx_test_sequence_select_i, // Transmit pattern
   input wire logic [1:0] jitter_attenuator_select_i, // Attenuator setup
   input wire logic rx_gain_range_select_i, // Equalizer range
   input wire logic receiver_sleep_pin_i, // Receiver power down
   input wire logic line_driver_float_i, // Driver high impedance
   input wire logic line_standard_e1_i, // E1 when high, T1/J1 when low
   // Multiplexed address/data lines
   input wire logic [7:0] ad_i, // Line levels
   output logic [7:0] ad_o, // Driven levels
   output logic ad_oe_n_o, // Drive enable, active low
   input wire logic [7:0] par_rd_data_i, // Read data from host bus logic
   input wire logic par_rd_en_i, // Host bus logic drives lines
   output logic [7:0] par_ad_o, // Line levels for host bus logic
   // Decoded controls
   output logic tx_all_ones_o, // Send all ones
   output logic tx_prbs_o, // Send pseudo-random sequence
   output logic tx_power_down_o, // Transmitter powered down
   output logic jit_enable_o, // Attenuator in use
   output logic jit_in_tx_path_o, // Attenuator in transmit path
   output logic jit_narrow_bw_o, // Narrow bandwidth
   output logic [7:0] jit_fifo_depth_o, // FIFO depth in bits
   output logic rx_power_down_o, // Receiver powered down
   output logic rx_long_haul_o, // Long haul equalizer
   output logic [5:0] rx_eq_range_db_o, // Equalizer range in dB
   output logic line_driver_en_o, // Line driver enabled
   output logic hw_mode_o, // Straps in control
   output logic in_reset_o // Reset state held
);

   // ****************************************
   // Reset release
   // ****************************************

   logic [1:0] rst_pipe_q;
   logic rst_n;

   // R8: clocked release
   // Release needs master clock edges; assertion is immediate
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_pipe_q <= 2'h0;
      end
      else
      begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe_q[1];

   localparam logic [2:0] RST_HOLD_CYC = 3'(`HMCPD_RST_MIN_CYC);

   logic [2:0] rst_hold_q;

   // R7: reset state hold
   // Decoded controls except hw_mode_o, and the AD drive enable, stay in the reset state for the minimum reset time after release
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_hold_q <= 3'h0;
      end
      else if (rst_hold_q != RST_HOLD_CYC)
      begin
         rst_hold_q <= rst_hold_q + 3'h1;
      end
   end

   logic settle;

   assign settle = (rst_hold_q == RST_HOLD_CYC);

   // ****************************************
   // Pin synchronisation
   // ****************************************

   localparam int SYNC_W = 18;

   logic [SYNC_W-1:0] pins_async;
   logic [SYNC_W-1:0] pins_sync;

   assign pins_async = {ad_i, line_standard_e1_i, line_driver_float_i, receiver_sleep_pin_i,
                        rx_gain_range_select_i, jitter_attenuator_select_i,
                        tx_test_sequence_select_i, ctrl_mode_sel_i};

   // R13: pin synchroniser
   hmcpd_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .async_i(pins_async),
      .sync_o(pins_sync)
   );

   hmcpd_ctrl_mode_t mode;
   logic [1:0] txseq_pin;
   logic [1:0] jit_pin;
   logic eq_pin;
   logic sleep_pin;
   logic float_pin;
   logic e1_pin;
   logic [7:0] ad_pin;
   logic hw_mode;

   assign mode = hmcpd_ctrl_mode_t'(pins_sync[1:0]);
   assign txseq_pin = pins_sync[3:2];
   assign jit_pin = pins_sync[5:4];
   assign eq_pin = pins_sync[6];
   assign sleep_pin = pins_sync[7];
   assign float_pin = pins_sync[8];
   assign e1_pin = pins_sync[9];
   assign ad_pin = pins_sync[17:10];

   // R12: hardware mode select
   assign hw_mode = (mode == HMCPD_MODE_HW);

   // ****************************************
   // APB slave
   // ****************************************

   // Register index for an address; 2'h3 marks an unmapped one
   function automatic logic [1:0] reg_index(input logic [7:0] addr);
      logic [1:0] idx;
      idx = 2'h3;
      if (addr == `HMCPD_OFS_SW_CFG)
      begin
         idx = 2'h0;
      end
      else if (addr == `HMCPD_OFS_STATUS)
      begin
         idx = 2'h1;
      end
      else if (addr == `HMCPD_OFS_VIOL)
      begin
         idx = 2'h2;
      end
      return idx;
   endfunction

   hmcpd_apb_state_t apb_state_q;
   logic apb_access;
   logic wr_commit;

   assign apb_access = psel_i && penable_i;
   assign wr_commit = (apb_state_q == HMCPD_APB_DONE) && apb_access && pwrite_i
                      && pstrb_i[0];

   // Answer one cycle into the access phase; pready comes from the state flop
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         apb_state_q <= HMCPD_APB_IDLE;
      end
      else
      begin
         unique case (apb_state_q)
            HMCPD_APB_IDLE:
            begin
               if (apb_access)
               begin
                  apb_state_q <= HMCPD_APB_DONE;
               end
            end
            HMCPD_APB_DONE:
            begin
               apb_state_q <= HMCPD_APB_IDLE;
            end
         endcase
      end
   end

   assign pready_o = apb_state_q[1];

   // ****************************************
   // Registers
   // ****************************************

   logic [7:0] sw_cfg_q;
   logic [1:0] viol_q;
   logic [1:0] viol_set;

   // Software configuration, byte lane 0 only
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sw_cfg_q <= `HMCPD_CFG_RESET;
      end
      else if (wr_commit && reg_index(paddr_i) == 2'h0)
      begin
         sw_cfg_q <= pwdata_i[7:0] & `HMCPD_CFG_WMASK;
      end
   end

   // R4: strap misuse check
   // Attenuator pins must read low outside hardware mode
   assign viol_set[`HMCPD_VIOL_JIT_BIT] = settle && !hw_mode && (jit_pin != 2'h0);

   // R11: serial tie check
   // Address/data lines must read low in serial mode
   assign viol_set[`HMCPD_VIOL_AD_BIT] = settle && (mode == HMCPD_MODE_SERIAL)
                                         && (ad_pin != 8'h00);

   // Sticky violations, write one to clear, a new event wins over the clear
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         viol_q <= 2'h0;
      end
      else if (wr_commit && reg_index(paddr_i) == 2'h2)
      begin
         viol_q <= (viol_q & ~pwdata_i[1:0]) | viol_set;
      end
      else
      begin
         viol_q <= viol_q | viol_set;
      end
   end

   // Read data and error, loaded as the answer is raised
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_o <= 32'h0;
         pslverr_o <= 1'b0;
      end
      else if (apb_state_q == HMCPD_APB_IDLE && apb_access)
      begin
         pslverr_o <= (reg_index(paddr_i) == 2'h3);
         prdata_o <= 32'h0;
         unique case (reg_index(paddr_i))
            2'h0: prdata_o <= {24'h0, sw_cfg_q};
            2'h1: prdata_o <= {16'h0, in_reset_o, line_driver_en_o, rx_power_down_o,
                               rx_long_haul_o, jit_in_tx_path_o, jit_narrow_bw_o, jit_enable_o,
                               tx_power_down_o, tx_prbs_o, tx_all_ones_o, 3'h0,
                               hw_mode_o, pins_sync[1:0]};
            2'h2: prdata_o <= {30'h0, viol_q};
            2'h3: prdata_o <= 32'h0;
         endcase
      end
      else if (apb_state_q == HMCPD_APB_DONE)
      begin
         pslverr_o <= 1'b0;
      end
   end

   // ****************************************
   // Configuration source
   // ****************************************

   logic [1:0] txseq_eff;
   logic [1:0] jit_eff;
   logic eq_eff;
   logic sleep_eff;
   logic e1_eff;

   // R13: ignore straps in software modes
   always_comb
   begin
      if (hw_mode)
      begin
         txseq_eff = txseq_pin;
         jit_eff = jit_pin;
         eq_eff = eq_pin;
         sleep_eff = sleep_pin;
         e1_eff = e1_pin;
      end
      else
      begin
         txseq_eff = sw_cfg_q[`HMCPD_CFG_TXSEQ_LSB +: 2];
         jit_eff = sw_cfg_q[`HMCPD_CFG_JIT_LSB +: 2];
         eq_eff = sw_cfg_q[`HMCPD_CFG_EQ_BIT];
         sleep_eff = sw_cfg_q[`HMCPD_CFG_SLEEP_BIT];
         e1_eff = sw_cfg_q[`HMCPD_CFG_E1_BIT];
      end
   end

   // ****************************************
   // Decoded controls
   // ****************************************

   // R1: transmit pattern decode
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_all_ones_o <= 1'b0;
         tx_prbs_o <= 1'b0;
         tx_power_down_o <= 1'b0;
      end
      else
      begin
         tx_all_ones_o <= settle && (txseq_eff == 2'h1);
         tx_prbs_o <= settle && (txseq_eff == 2'h2);
         tx_power_down_o <= settle && (txseq_eff == 2'h3);
      end
   end

   // R2: attenuator off or broad
   // R3: attenuator narrow placement
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         jit_enable_o <= 1'b0;
         jit_in_tx_path_o <= 1'b0;
         jit_narrow_bw_o <= 1'b0;
         jit_fifo_depth_o <= 8'h0;
      end
      else
      begin
         jit_enable_o <= settle && (jit_eff != 2'h0);
         jit_in_tx_path_o <= settle && (jit_eff == 2'h3);
         jit_narrow_bw_o <= settle && jit_eff[1];
         if (!settle || jit_eff == 2'h0)
         begin
            jit_fifo_depth_o <= 8'h0;
         end
         else if (jit_eff == 2'h1)
         begin
            jit_fifo_depth_o <= `HMCPD_FIFO_BROAD;
         end
         else
         begin
            jit_fifo_depth_o <= `HMCPD_FIFO_NARROW;
         end
      end
   end

   // R5: receiver sleep
   // R6: equalizer range
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_power_down_o <= 1'b0;
         rx_long_haul_o <= 1'b0;
         rx_eq_range_db_o <= 6'h0;
      end
      else
      begin
         rx_power_down_o <= settle && sleep_eff;
         rx_long_haul_o <= settle && eq_eff;
         if (!settle)
         begin
            rx_eq_range_db_o <= 6'h0;
         end
         else if (!eq_eff)
         begin
            rx_eq_range_db_o <= `HMCPD_EQ_SHORT_DB;
         end
         else if (e1_eff)
         begin
            rx_eq_range_db_o <= `HMCPD_EQ_LONG_E1_DB;
         end
         else
         begin
            rx_eq_range_db_o <= `HMCPD_EQ_LONG_T1_DB;
         end
      end
   end

   // R9: driver float
   // R10: float touches driver only
   // The float pin acts in every mode and feeds nothing but the driver enable
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_driver_en_o <= 1'b0;
      end
      else
      begin
         line_driver_en_o <= settle && !float_pin;
      end
   end

   // Mode and reset state indications
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hw_mode_o <= 1'b0;
         in_reset_o <= 1'b1;
      end
      else
      begin
         hw_mode_o <= hw_mode;
         in_reset_o <= !settle;
      end
   end

   // ****************************************
   // Multiplexed address/data lines
   // ****************************************

   logic par_mode;

   assign par_mode = (mode == HMCPD_MODE_PAR_A) || (mode == HMCPD_MODE_PAR_B);

   // R11: shared bidirectional lines
   // Lines are driven only for a parallel read; in serial mode they stay inputs
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ad_o <= 8'h0;
         ad_oe_n_o <= 1'b1;
         par_ad_o <= 8'h0;
      end
      else
      begin
         ad_o <= par_rd_data_i;
         ad_oe_n_o <= !(settle && par_mode && par_rd_en_i);
         par_ad_o <= par_mode ? ad_pin : 8'h00;
      end
   end

endmodule

// *** test/hmcpd_top_props.sv ***
// Checker on the strap decoder top module ports
`timescale 1ns/100ps
`include "hmcpd_consts.svh"

module hmcpd_top_props (
   input wire logic sys_clk_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire logic psel_i, // Select
   input wire logic penable_i, // Access
   input wire logic pready_o, // Done
   input wire logic [1:0] tx_test_sequence_select_i, // Pattern
   input wire logic [1:0] jitter_attenuator_select_i, // Attenuator
   input wire logic rx_gain_range_select_i, // Gain
   input wire logic receiver_sleep_pin_i, // Sleep
   input wire logic line_driver_float_i, // Float
   input wire logic line_standard_e1_i, // E1
   input wire logic tx_all_ones_o, // Ones
   input wire logic tx_prbs_o, // Sequence
   input wire logic tx_power_down_o, // Tx off
   input wire logic jit_enable_o, // On
   input wire logic jit_in_tx_path_o, // Tx side
   input wire logic jit_narrow_bw_o, // Narrow
   input wire logic [7:0] jit_fifo_depth_o, // Depth
   input wire logic rx_power_down_o, // Rx off
   input wire logic rx_long_haul_o, // Long
   input wire logic [5:0] rx_eq_range_db_o, // Range
   input wire logic line_driver_en_o, // Driver
   input wire logic hw_mode_o, // Straps rule
   input wire logic in_reset_o // Held
);
   // ****************************************
   // Checks
   // ****************************************
   // Out of reset a full cycle, so pin history behind the outputs is real
   logic settled_q;
   logic live;

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
      if (!rst_n_i)
         settled_q <= 1'b0;
      else
         settled_q <= !in_reset_o;
   assign live = settled_q && !in_reset_o;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   pattern_decode_a: assert property (live && hw_mode_o |->
      tx_all_ones_o == ($past(tx_test_sequence_select_i, 3) == 2'h1) &&
      tx_prbs_o == ($past(tx_test_sequence_select_i, 3) == 2'h2) &&
      tx_power_down_o == ($past(tx_test_sequence_select_i, 3) == 2'h3))
      else $error("pattern outputs wrong");
   jit_broad_a: assert property (live && hw_mode_o &&
      !$past(jitter_attenuator_select_i[1], 3) |->
      jit_enable_o == $past(jitter_attenuator_select_i[0], 3) && !jit_narrow_bw_o &&
      !jit_in_tx_path_o && jit_fifo_depth_o == (jit_enable_o ? `HMCPD_FIFO_BROAD : 8'h00))
      else $error("attenuator off or broad setup wrong");
   jit_narrow_a: assert property (live && hw_mode_o &&
      $past(jitter_attenuator_select_i[1], 3) |->
      jit_enable_o && jit_narrow_bw_o && jit_fifo_depth_o == `HMCPD_FIFO_NARROW &&
      jit_in_tx_path_o == $past(jitter_attenuator_select_i[0], 3))
      else $error("attenuator narrow setup wrong");
   sw_ignore_a: assert property (!in_reset_o && !hw_mode_o && !$past(hw_mode_o) &&
      !$past(psel_i) && !$past(psel_i, 2) |-> $stable(jit_enable_o) && $stable(tx_prbs_o) &&
      $stable(rx_long_haul_o)) else $error("straps acted in software mode");
   rx_sleep_a: assert property (live && hw_mode_o |->
      rx_power_down_o == $past(receiver_sleep_pin_i, 3)) else $error("receiver sleep wrong");
   eq_range_a: assert property (live && hw_mode_o |->
      rx_long_haul_o == $past(rx_gain_range_select_i, 3) && rx_eq_range_db_o ==
      (!rx_long_haul_o ? `HMCPD_EQ_SHORT_DB : $past(line_standard_e1_i, 3) ?
      `HMCPD_EQ_LONG_E1_DB : `HMCPD_EQ_LONG_T1_DB)) else $error("equalizer range wrong");
   driver_float_a: assert property (live |->
      line_driver_en_o == !$past(line_driver_float_i, 3)) else $error("driver enable wrong");
   reset_state_a: assert property (disable iff (1'b0) !rst_n_i ##1 !rst_n_i |->
      in_reset_o && !pready_o && !line_driver_en_o && !tx_prbs_o && !jit_enable_o)
      else $error("reset state not held");
   apb_answer_a: assert property (psel_i && $rose(penable_i) |=> pready_o ##1 !pready_o)
      else $error("ready not one cycle after access");
endmodule

bind hmcpd_top hmcpd_top_props hmcpd_top_props_i (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .tx_test_sequence_select_i(tx_test_sequence_select_i),
   .jitter_attenuator_select_i(jitter_attenuator_select_i),
   .rx_gain_range_select_i(rx_gain_range_select_i), .receiver_sleep_pin_i(receiver_sleep_pin_i),
   .line_driver_float_i(line_driver_float_i), .line_standard_e1_i(line_standard_e1_i),
   .tx_all_ones_o(tx_all_ones_o), .tx_prbs_o(tx_prbs_o), .tx_power_down_o(tx_power_down_o),
   .jit_enable_o(jit_enable_o), .jit_in_tx_path_o(jit_in_tx_path_o),
   .jit_narrow_bw_o(jit_narrow_bw_o), .jit_fifo_depth_o(jit_fifo_depth_o),
   .rx_power_down_o(rx_power_down_o), .rx_long_haul_o(rx_long_haul_o),
   .rx_eq_range_db_o(rx_eq_range_db_o), .line_driver_en_o(line_driver_en_o),
   .hw_mode_o(hw_mode_o), .in_reset_o(in_reset_o));

// *** test/hmcpd_board_model.sv ***
// Board model: attenuator straps and the shared bus lines
`timescale 1ns/100ps

module hmcpd_board_model (
   input wire logic clk_i, // Master clock
   input wire logic [1:0] mode_i, // Control mode pins
   input wire logic [1:0] jit_want_i, // Attenuator strap wanted
   input wire logic jit_break_i, // Leave attenuator straps up in software mode
   input wire logic host_drv_i, // Host drives the lines
   input wire logic [7:0] host_val_i, // Host value
   input wire logic [7:0] ad_o_i, // Device value
   input wire logic ad_oe_n_i, // Device drives, active low
   output logic [1:0] jit_o, // Attenuator pins
   output logic [7:0] ad_line_o // Resolved line levels
);
   logic [7:0] last_q = 8'h00;

   assign jit_o = (mode_i == 2'h0 || jit_break_i) ? jit_want_i : 2'h0;

   // lines resolved, serial mode pulled low, else float
   always_comb
      if (!ad_oe_n_i)
         ad_line_o = ad_o_i;
      else if (host_drv_i)
         ad_line_o = host_val_i;
      else if (mode_i == 2'h1)
         ad_line_o = 8'h00;
      else
         ad_line_o = ~last_q;

   // Remember the last level so a floating line never repeats it
   always_ff @(posedge clk_i)
      last_q <= ad_line_o;
endmodule

// *** test/hmcpd_top_tb_top.sv ***
// Self-checking bench for the strap decoder
`timescale 1ns/100ps
`include "hmcpd_consts.svh"

module hmcpd_top_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] mode = 2'h0;
   logic [7:0] strap = 8'h00;
   logic jit_break = 1'b0;
   logic host_drv = 1'b0;
   logic [7:0] host_val = 8'h00;
   logic [7:0] rd_data = 8'h00;
   logic rd_en = 1'b0;
   logic [31:0] rd;
   logic er;
   int bad_count = 0;
   int cmp_count = 0;
   wire [31:0] prdata;
   wire [22:0] dec;
   wire [7:0] ad_drv, ad_line, par_ad;
   wire [1:0] jit_pin;
   wire pready, pslverr, ad_oe_n, hw_mode, in_rst;
   // Rows: strap pins {pattern, attenuator, gain, sleep, float, E1}, then decoded outputs
   logic [30:0] rows [4] = '{
      {8'h00, 3'h0, 3'h0, 8'h00, 2'h0, 6'h0a, 1'h1},
      {8'h5e, 3'h4, 3'h4, 8'h40, 2'h3, 6'h24, 1'h0},
      {8'ha9, 3'h2, 3'h5, 8'h80, 2'h1, 6'h2b, 1'h1},
      {8'hf5, 3'h1, 3'h7, 8'h80, 2'h2, 6'h0a, 1'h1}};

   always #12.5 clk = ~clk;

   hmcpd_top hmcpd_top_i (
      .sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .ctrl_mode_sel_i(mode), .tx_test_sequence_select_i(strap[7:6]),
      .jitter_attenuator_select_i(jit_pin), .rx_gain_range_select_i(strap[3]),
      .receiver_sleep_pin_i(strap[2]), .line_driver_float_i(strap[1]),
      .line_standard_e1_i(strap[0]), .ad_i(ad_line), .ad_o(ad_drv), .ad_oe_n_o(ad_oe_n),
      .par_rd_data_i(rd_data), .par_rd_en_i(rd_en), .par_ad_o(par_ad),
      .tx_all_ones_o(dec[22]), .tx_prbs_o(dec[21]), .tx_power_down_o(dec[20]),
      .jit_enable_o(dec[19]), .jit_in_tx_path_o(dec[18]), .jit_narrow_bw_o(dec[17]),
      .jit_fifo_depth_o(dec[16:9]), .rx_power_down_o(dec[8]), .rx_long_haul_o(dec[7]),
      .rx_eq_range_db_o(dec[6:1]), .line_driver_en_o(dec[0]), .hw_mode_o(hw_mode),
      .in_reset_o(in_rst));

   hmcpd_board_model hmcpd_board_model_i (
      .clk_i(clk), .mode_i(mode), .jit_want_i(strap[5:4]), .jit_break_i(jit_break),
      .host_drv_i(host_drv), .host_val_i(host_val), .ad_o_i(ad_drv), .ad_oe_n_i(ad_oe_n),
      .jit_o(jit_pin), .ad_line_o(ad_line));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for ready, which should come on the second access edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n, 32'h2);
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      chk(32'({in_rst, pready, ad_oe_n, dec[0]}), 32'ha);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
      chk(32'(in_rst), 32'h0);
      foreach (rows[i])
      begin
         strap <= rows[i][30:23];
         repeat (5) @(posedge clk);
         chk(32'({hw_mode, dec}), 32'({1'b1, rows[i][22:0]}));
      end
      // Serial mode: register setup rules, pattern straps ignored
      mode <= 2'h1;
      strap <= 8'h40;
      apb(1'b1, `HMCPD_OFS_SW_CFG, 32'h5e);
      repeat (5) @(posedge clk);
      chk(32'({dec, par_ad}), 32'({3'h2, 3'h7, 8'h80, 2'h1, 6'h2b, 1'h1, 8'h00}));
      apb(1'b0, `HMCPD_OFS_SW_CFG, 32'h0);
      chk(rd, 32'h5e);
      strap <= 8'h42;
      repeat (5) @(posedge clk);
      chk(32'(dec), 32'({3'h2, 3'h7, 8'h80, 2'h1, 6'h2b, 1'h0}));
      apb(1'b1, `HMCPD_OFS_STATUS, 32'hffff);
      apb(1'b0, `HMCPD_OFS_STATUS, 32'h0);
      chk(rd, 32'h1e81);
      apb(1'b0, 8'h0c, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      // Attenuator straps left up and a bus line high in serial mode
      jit_break <= 1'b1;
      host_drv <= 1'b1;
      host_val <= 8'h01;
      strap <= 8'h52;
      repeat (5) @(posedge clk);
      chk(32'(dec[19:17]), 32'h7);
      jit_break <= 1'b0;
      host_drv <= 1'b0;
      apb(1'b0, `HMCPD_OFS_VIOL, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, `HMCPD_OFS_VIOL, 32'h3);
      apb(1'b0, `HMCPD_OFS_VIOL, 32'h0);
      chk(rd, 32'h0);
      // Multiplexed mode: device then host on the shared lines
      mode <= 2'h2;
      rd_en <= 1'b1;
      rd_data <= 8'ha5;
      repeat (5) @(posedge clk);
      chk(32'({ad_oe_n, ad_drv}), 32'ha5);
      rd_en <= 1'b0;
      mode <= 2'h3;
      host_drv <= 1'b1;
      host_val <= 8'h3c;
      repeat (5) @(posedge clk);
      chk(32'(par_ad), 32'h3c);
      host_drv <= 1'b0;
      // Second reset in mid-run
      mode <= 2'h0;
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk(32'({in_rst, dec[0], pready}), 32'h4);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
      chk(32'({in_rst, hw_mode}), 32'h1);
      close_out();
   end

   // Watchdog against a hang
   initial
   begin
      #(25 * 3000);
      bad_count++;
      $display("mismatch at %0t: run did not finish", $time);
      close_out();
   end
endmodule
